// ---- rtl/vfs_pkg.sv ----
// Operation
// R1: 5-bit format code from pins or host bits; seven codes are reserved.
// R2: code 00000 carries muxed samples on luma bus at 27 MHz, chroma low.
// R3: code 00010 carries muxed samples on luma bus at 36 MHz, chroma low.
// R4: codes 00100/00110 carry muxed luma-bus samples at 27/36 MHz.
// R5: code 01000 is one luma-bus stream at 54 MHz with embedded timing.
// R6: codes 01100/01101 are luma-bus streams at 54/72 MHz, embedded timing.
// R7: code 01110 uses both buses at 27 MHz with external strobes.
// R8: code 01111 is one luma-bus stream at 27/36 MHz, external strobes.
// R9: 720-line progressive codes use separate buses at 74.25 MHz rates.
// R10: 1080-line progressive codes use separate buses at 74.25 MHz rates.
// R11: interlaced high-definition codes use separate buses at 74.25 MHz.
// R12: segmented-frame codes use separate buses at 74.25 MHz rates.
// R13: code 11111 uses separate buses with external strobes.
// R14: either sync-enable pin or host bit high selects external strobes.
// R15: both low selects embedded timing codes; strobes are ignored.
// R16: 8-bit video sits on the upper bits, two low bits held low.
// R17: format and sync choice are registered and applied at field change.
package vfs_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int CTRL_HOST_SEL_BIT = 0;
  localparam int CTRL_EXT_SYNC_BIT = 1;
  localparam int CTRL_CODE_LSB = 4;
  localparam int STAT_CODE_LSB = 0;
  localparam int STAT_EXT_BIT = 5;
  localparam int STAT_SEP_BIT = 6;
  localparam int STAT_RSVD_BIT = 7;
  localparam int STAT_PEND_BIT = 8;
  localparam int STAT_CLK_LSB = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // video constants
  // ----------------------------------------------------------------
  localparam logic [4:0] FMT_RST = 5'h00;
  localparam logic [7:0] TRS_WORD0 = 8'hff;
  localparam logic [7:0] TRS_WORD1 = 8'h00;
  localparam int TRS_F_BIT = 8;
  localparam int TRS_V_BIT = 7;
  localparam int TRS_H_BIT = 6;
  localparam int SYNC_STAGES = 3;

  typedef enum logic [2:0] {
    VFS_CLK_27 = 3'h0,
    VFS_CLK_36 = 3'h1,
    VFS_CLK_27_36 = 3'h2,
    VFS_CLK_54 = 3'h3,
    VFS_CLK_72 = 3'h4,
    VFS_CLK_74 = 3'h5,
    VFS_CLK_NONE = 3'h7
  } vfs_clk_t;

  typedef struct packed {
    logic reserved;
    logic sep_yc;
    logic force_ext;
    logic force_trs;
    vfs_clk_t clk;
  } vfs_fmt_t;

  typedef struct packed {
    logic f;
    logic v;
    logic h;
  } vfs_sync_t;

  // ----------------------------------------------------------------
  // format code decode
  // ----------------------------------------------------------------
  function automatic vfs_fmt_t vfs_decode(input logic [4:0] code);
    vfs_fmt_t r;
    r = '{reserved: 1'b0, sep_yc: code[4], force_ext: 1'b0,
          force_trs: 1'b0, clk: VFS_CLK_74};
    case (code)
      5'h00, 5'h04: r.clk = VFS_CLK_27;
      5'h02, 5'h06: r.clk = VFS_CLK_36;
      5'h08, 5'h0c: begin
        r.clk = VFS_CLK_54;
        r.force_trs = 1'b1;
      end
      5'h0d: begin
        r.clk = VFS_CLK_72;
        r.force_trs = 1'b1;
      end
      5'h0e: begin
        r.clk = VFS_CLK_27;
        r.sep_yc = 1'b1;
        r.force_ext = 1'b1;
      end
      5'h0f: begin
        r.clk = VFS_CLK_27_36;
        r.force_ext = 1'b1;
      end
      5'h1f: r.force_ext = 1'b1;
      5'h01, 5'h03, 5'h05, 5'h07, 5'h09, 5'h0a, 5'h0b: begin
        r.reserved = 1'b1;
        r.clk = VFS_CLK_NONE;
      end
      default: r.clk = VFS_CLK_74;
    endcase
    return r;
  endfunction : vfs_decode

endpackage : vfs_pkg

// ---- rtl/vfs_top.sv ----
module vfs_top (
  input wire logic REF_CLK_IN, // video clock
  input wire logic SRST_IN, // sync reset, high
  input wire logic [3:0] S_AXI_AWADDR_IN, // write address
  input wire logic S_AXI_AWVALID_IN, // write address valid
  output logic S_AXI_AWREADY_OUT, // write address ready
  input wire logic [31:0] S_AXI_WDATA_IN, // write data
  input wire logic [3:0] S_AXI_WSTRB_IN, // write byte enables
  input wire logic S_AXI_WVALID_IN, // write data valid
  output logic S_AXI_WREADY_OUT, // write data ready
  output logic [1:0] S_AXI_BRESP_OUT, // write response
  output logic S_AXI_BVALID_OUT, // write response valid
  input wire logic S_AXI_BREADY_IN, // write response ready
  input wire logic [3:0] S_AXI_ARADDR_IN, // read address
  input wire logic S_AXI_ARVALID_IN, // read address valid
  output logic S_AXI_ARREADY_OUT, // read address ready
  output logic [31:0] S_AXI_RDATA_OUT, // read data
  output logic [1:0] S_AXI_RRESP_OUT, // read response
  output logic S_AXI_RVALID_OUT, // read data valid
  input wire logic S_AXI_RREADY_IN, // read data ready
  input wire logic [4:0] FORMAT_SELECT_CODE_IN, // format code pins
  input wire logic EXTERNAL_SYNC_ENABLE_IN, // sync source pin
  input wire logic [9:0] Y_IN, // luma or muxed bus
  input wire logic [9:0] C_IN, // chroma bus
  input wire logic F_IN, // field strobe
  input wire logic V_IN, // vertical strobe
  input wire logic H_IN, // horizontal strobe
  output logic [9:0] Y_OUT, // luma out
  output logic [9:0] C_OUT, // chroma out
  output logic F_OUT, // field timing
  output logic V_OUT, // vertical timing
  output logic H_OUT // horizontal timing
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [5:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_reg;
  logic [31:0] ctrl_reg;
  logic aw_rdy_reg, aw_have_reg, w_rdy_reg, w_have_reg, b_vld_reg;
  logic [3:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [1:0] b_resp_reg, r_resp_reg;
  logic ar_rdy_reg, r_vld_reg;
  logic [31:0] r_data_reg;
  logic [7:0] hist0_reg, hist1_reg, hist2_reg;
  vfs_pkg::vfs_sync_t trs_reg, sel, out_sync_reg;
  logic [9:0] y_reg, c_reg;
  logic [4:0] act_code_reg;
  logic act_ext_reg;
  logic wr_fire, trs_hit, field_edge;
  logic [4:0] req_code;
  logic req_ext, req_ext_eff;
  vfs_pkg::vfs_fmt_t req_info, act_info;
  logic [31:0] status;

  // ----------------------------------------------------------------
  // strap pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      pin_s1_reg <= 6'h00;
      pin_s2_reg <= 6'h00;
      pin_s3_reg <= 6'h00;
      pin_reg <= 6'h00;
    end else begin
      pin_s1_reg <= {EXTERNAL_SYNC_ENABLE_IN, FORMAT_SELECT_CODE_IN};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      if (pin_s2_reg == pin_s3_reg) begin
        pin_reg <= pin_s3_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi write channels
  // ----------------------------------------------------------------
  assign wr_fire = aw_have_reg && w_have_reg && !b_vld_reg;

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      aw_rdy_reg <= 1'b0;
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_rdy_reg <= 1'b0;
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      b_vld_reg <= 1'b0;
      b_resp_reg <= vfs_pkg::RESP_OKAY;
    end else begin
      if (aw_rdy_reg && S_AXI_AWVALID_IN) begin
        aw_addr_reg <= S_AXI_AWADDR_IN;
        aw_have_reg <= 1'b1;
        aw_rdy_reg <= 1'b0;
      end else if (!aw_have_reg && !b_vld_reg) begin
        aw_rdy_reg <= 1'b1;
      end
      if (w_rdy_reg && S_AXI_WVALID_IN) begin
        w_data_reg <= S_AXI_WDATA_IN;
        w_strb_reg <= S_AXI_WSTRB_IN;
        w_have_reg <= 1'b1;
        w_rdy_reg <= 1'b0;
      end else if (!w_have_reg && !b_vld_reg) begin
        w_rdy_reg <= 1'b1;
      end
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        b_vld_reg <= 1'b1;
        b_resp_reg <= (aw_addr_reg == vfs_pkg::ADDR_CTRL) ?
                      vfs_pkg::RESP_OKAY : vfs_pkg::RESP_SLVERR;
      end else if (b_vld_reg && S_AXI_BREADY_IN) begin
        b_vld_reg <= 1'b0;
      end
    end
  end

  // control register, byte lanes
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      ctrl_reg <= vfs_pkg::CTRL_RST;
    end else if (wr_fire && aw_addr_reg == vfs_pkg::ADDR_CTRL) begin
      for (int i = 0; i < 4; i++) begin
        if (w_strb_reg[i]) begin
          ctrl_reg[i*8 +: 8] <= w_data_reg[i*8 +: 8];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  always_comb begin
    status = 32'h0000_0000;
    status[vfs_pkg::STAT_CODE_LSB +: 5] = act_code_reg;
    status[vfs_pkg::STAT_EXT_BIT] = act_ext_reg;
    status[vfs_pkg::STAT_SEP_BIT] = act_info.sep_yc;
    status[vfs_pkg::STAT_RSVD_BIT] = req_info.reserved;
    status[vfs_pkg::STAT_PEND_BIT] = (req_code != act_code_reg) ||
                                     (req_ext_eff != act_ext_reg);
    status[vfs_pkg::STAT_CLK_LSB +: 3] = act_info.clk;
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      ar_rdy_reg <= 1'b0;
      r_vld_reg <= 1'b0;
      r_data_reg <= 32'h0000_0000;
      r_resp_reg <= vfs_pkg::RESP_OKAY;
    end else if (ar_rdy_reg && S_AXI_ARVALID_IN) begin
      ar_rdy_reg <= 1'b0;
      r_vld_reg <= 1'b1;
      r_resp_reg <= vfs_pkg::RESP_OKAY;
      case (S_AXI_ARADDR_IN)
        vfs_pkg::ADDR_CTRL: r_data_reg <= ctrl_reg;
        vfs_pkg::ADDR_STATUS: r_data_reg <= status;
        default: begin
          r_data_reg <= 32'h0000_0000;
          r_resp_reg <= vfs_pkg::RESP_SLVERR;
        end
      endcase
    end else if (r_vld_reg && S_AXI_RREADY_IN) begin
      r_vld_reg <= 1'b0;
    end else if (!r_vld_reg) begin
      ar_rdy_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // format and sync request
  // ----------------------------------------------------------------
  assign req_code = ctrl_reg[vfs_pkg::CTRL_HOST_SEL_BIT] ?
                    ctrl_reg[vfs_pkg::CTRL_CODE_LSB +: 5] : pin_reg[4:0]; // R1
  assign req_ext = pin_reg[5] | ctrl_reg[vfs_pkg::CTRL_EXT_SYNC_BIT]; // R14
  assign req_info = vfs_pkg::vfs_decode(req_code); // R1
  assign act_info = vfs_pkg::vfs_decode(act_code_reg); // R9 R10 R11 R12
  // generic codes need strobes, progressive sd needs embedded codes
  assign req_ext_eff = req_info.force_ext |
                       (!req_info.force_trs & req_ext); // R7 R8 R13 R5 R6 R15

  // ----------------------------------------------------------------
  // embedded timing code extraction
  // ----------------------------------------------------------------
  // only the upper eight bits are compared so 8-bit sources match
  assign trs_hit = hist2_reg == vfs_pkg::TRS_WORD0 &&
                   hist1_reg == vfs_pkg::TRS_WORD1 &&
                   hist0_reg == vfs_pkg::TRS_WORD1; // R16

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      hist0_reg <= 8'h00;
      hist1_reg <= 8'h00;
      hist2_reg <= 8'h00;
      trs_reg <= '0;
    end else begin
      hist0_reg <= Y_IN[9:2];
      hist1_reg <= hist0_reg;
      hist2_reg <= hist1_reg;
      if (trs_hit) begin
        trs_reg <= '{f: Y_IN[vfs_pkg::TRS_F_BIT],
                     v: Y_IN[vfs_pkg::TRS_V_BIT],
                     h: Y_IN[vfs_pkg::TRS_H_BIT]};
      end
    end
  end

  // ----------------------------------------------------------------
  // sync source and field-boundary apply
  // ----------------------------------------------------------------
  always_comb begin
    if (act_ext_reg) begin
      sel = '{f: F_IN, v: V_IN, h: H_IN}; // R14
    end else begin
      sel = trs_reg; // R15
    end
  end

  assign field_edge = sel.f != out_sync_reg.f;

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      act_code_reg <= vfs_pkg::FMT_RST;
      act_ext_reg <= 1'b0;
    end else if (field_edge && !req_info.reserved) begin
      act_code_reg <= req_code; // R17
      act_ext_reg <= req_ext_eff; // R17
    end
  end

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      out_sync_reg <= '0;
      y_reg <= 10'h000;
      c_reg <= 10'h000;
    end else begin
      out_sync_reg <= sel;
      y_reg <= Y_IN; // R2 R3 R4
      c_reg <= act_info.sep_yc ? C_IN : 10'h000; // R2 R3 R4 R9
    end
  end

  assign S_AXI_AWREADY_OUT = aw_rdy_reg;
  assign S_AXI_WREADY_OUT = w_rdy_reg;
  assign S_AXI_BVALID_OUT = b_vld_reg;
  assign S_AXI_BRESP_OUT = b_resp_reg;
  assign S_AXI_ARREADY_OUT = ar_rdy_reg;
  assign S_AXI_RVALID_OUT = r_vld_reg;
  assign S_AXI_RDATA_OUT = r_data_reg;
  assign S_AXI_RRESP_OUT = r_resp_reg;
  assign Y_OUT = y_reg;
  assign C_OUT = c_reg;
  assign F_OUT = out_sync_reg.f;
  assign V_OUT = out_sync_reg.v;
  assign H_OUT = out_sync_reg.h;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (SRST_IN);

  cfg_hold_a: assert property ( // R17
    !field_edge |=> $stable(act_code_reg) && $stable(act_ext_reg))
    else $error("format changed away from a field boundary");
  cfg_apply_a: assert property ( // R17
    field_edge && !req_info.reserved |=>
      act_code_reg == $past(req_code) && act_ext_reg == $past(req_ext_eff))
    else $error("field boundary did not apply request");
  rsvd_block_a: assert property ( // R1
    field_edge && req_info.reserved |=> $stable(act_code_reg))
    else $error("reserved format code was applied");
  ext_follow_a: assert property ( // R14
    act_ext_reg |=> F_OUT == $past(F_IN) && H_OUT == $past(H_IN))
    else $error("external strobes not followed");
  trs_follow_a: assert property ( // R15
    !act_ext_reg && trs_hit ##1 !act_ext_reg |=>
      F_OUT == $past(Y_IN[vfs_pkg::TRS_F_BIT], 2) &&
      V_OUT == $past(Y_IN[vfs_pkg::TRS_V_BIT], 2))
    else $error("embedded timing not extracted");
  chroma_zero_a: assert property ( // R2
    !act_info.sep_yc |=> C_OUT == 10'h000)
    else $error("chroma passed for multiplexed format");
  chroma_pass_a: assert property ( // R9
    act_info.sep_yc |=> C_OUT == $past(C_IN))
    else $error("chroma lost for separate format");
  generic_ext_a: assert property ( // R13
    act_info.force_ext |-> act_ext_reg)
    else $error("generic format without external strobes");
  prog_trs_a: assert property ( // R5
    act_info.force_trs |-> !act_ext_reg)
    else $error("progressive sd format without embedded timing");
  rsvd_never_a: assert property ( // R1
    !act_info.reserved)
    else $error("active format code is reserved");

  switch_c: cover property (field_edge && req_code != act_code_reg);
  rsvd_c: cover property (field_edge && req_info.reserved);
  trs_c: cover property (trs_hit && !act_ext_reg);
  ext_c: cover property (act_ext_reg && field_edge);

endmodule : vfs_top

// ---- testbench/vfs_vsrc.sv ----
module vfs_vsrc (
  input wire logic clk_in, // video clock
  input wire logic sep_in, // drive chroma bus
  input wire logic [2:0] fvh_in, // strobe levels f,v,h
  input wire logic go_in, // start a timing code
  input wire logic [2:0] tfvh_in, // embedded f,v,h
  output logic [9:0] y_out = 10'h000, // luma bus
  output logic [9:0] c_out = 10'h000, // chroma bus
  output vfs_pkg::vfs_sync_t s_out = 3'h0 // strobes
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [6:0] cnt_reg = 7'h00;
  logic [2:0] step_reg = 3'h0;

  // --------------------------------------------------------------
  // source stream, 8-bit samples on the upper bits
  // --------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    cnt_reg <= cnt_reg + 7'h01;
    step_reg <= go_in ? 3'h1 : (step_reg == 3'h0 ? 3'h0 : step_reg + 3'h1);
    s_out <= fvh_in;
    c_out <= sep_in ? {~cnt_reg, 3'h0} : 10'h000;
    case (step_reg)
      3'h1: y_out <= 10'h3fc;
      3'h2, 3'h3: y_out <= 10'h000;
      3'h4: y_out <= {1'h1, tfvh_in, 6'h00};
      default: y_out <= {1'h0, cnt_reg, 2'h0};
    endcase
  end
endmodule : vfs_vsrc

// ---- testbench/vfs_top_tb.sv ----
module vfs_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
  logic rready = 1'h0, pin_ext = 1'h0, go = 1'h0, sep = 1'h0, fld = 1'h0;
  logic [4:0] pin_code = 5'h00, a_code = 5'h00;
  logic [2:0] fvh = 3'h0, tfvh = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, f_o, v_o, h_o;
  logic [1:0] bresp, rresp, r;
  logic [9:0] y_i, c_i, y_o, c_o;
  vfs_pkg::vfs_sync_t str;
  int n_fail = 0;
  int comparisons = 0;

  always #12.5 clk = ~clk;

  vfs_top i_dut (.REF_CLK_IN(clk), .SRST_IN(srst),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
    .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
    .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wvalid),
    .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
    .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
    .S_AXI_RREADY_IN(rready), .FORMAT_SELECT_CODE_IN(pin_code),
    .EXTERNAL_SYNC_ENABLE_IN(pin_ext), .Y_IN(y_i), .C_IN(c_i),
    .F_IN(str.f), .V_IN(str.v), .H_IN(str.h), .Y_OUT(y_o), .C_OUT(c_o),
    .F_OUT(f_o), .V_OUT(v_o), .H_OUT(h_o));

  vfs_vsrc i_src (.clk_in(clk), .sep_in(sep), .fvh_in(fvh), .go_in(go),
    .tfvh_in(tfvh), .y_out(y_i), .c_out(c_i), .s_out(str));

  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, s);
    comparisons++;
    if (s !== e) begin
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
      n_fail++;
    end
  endtask : chk

  task automatic end_of_test;
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    r = bresp;
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask : rd

  function automatic logic [31:0] exp_st(input logic [4:0] c,
                                         input logic x, input logic rv);
    logic [2:0] k;
    case (c)
      5'h00, 5'h04, 5'h0e: k = 3'h0;
      5'h02, 5'h06: k = 3'h1;
      5'h0f: k = 3'h2;
      5'h08, 5'h0c: k = 3'h3;
      5'h0d: k = 3'h4;
      default: k = 3'h5;
    endcase
    if (c inside {5'h0e, 5'h0f, 5'h1f}) x = 1'h1;
    if (c inside {5'h08, 5'h0c, 5'h0d}) x = 1'h0;
    return {17'h0, k, 4'h0, rv, c[4] | (c == 5'h0e), x, c};
  endfunction : exp_st

  // field change on both timing sources
  task automatic flip;
    @(posedge clk);
    fld = ~fld;
    fvh <= {fld, fld, ~fld};
    tfvh <= {fld, 2'h0};
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    repeat (8) @(posedge clk);
  endtask : flip

  task automatic chk_video(input logic x, input logic s);
    logic [9:0] y, c;
    logic [2:0] t;
    @(posedge clk);
    #1;
    y = y_i;
    c = s ? c_i : 10'h000;
    t = str;
    @(posedge clk);
    #1;
    chk("luma out", y, y_o);
    chk("chroma out", c, c_o);
    if (x) chk("strobes out", t, {f_o, v_o, h_o});
  endtask : chk_video

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_regs;
    rd(4'h0);
    chk("ctrl reset", 32'h0, d);
    rd(4'h4);
    chk("status reset", exp_st(5'h00, 1'h0, 1'h0), d);
    rd(4'h8);
    chk("unmapped read", {30'h0, vfs_pkg::RESP_SLVERR}, {d[29:0], r});
    wr(4'h4, 32'hffff_ffff);
    chk("status write resp", vfs_pkg::RESP_SLVERR, r);
    wr(4'hc, 32'h1);
    chk("unmapped write resp", vfs_pkg::RESP_SLVERR, r);
    rd(4'h4);
    chk("status kept", exp_st(5'h00, 1'h0, 1'h0), d);
  endtask : t_regs

  task automatic t_trs;
    int n;
    @(posedge clk);
    fvh <= 3'h3;
    tfvh <= {fld, 2'h2};
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (y_i !== {1'h1, fld, 2'h2, 6'h00} && n < 20);
    repeat (2) @(posedge clk);
    #1;
    chk("embedded timing", {fld, 2'h2}, {f_o, v_o, h_o});
    repeat (3) @(posedge clk);
    #1;
    chk("strobes ignored", {fld, 2'h2}, {f_o, v_o, h_o});
  endtask : t_trs

  task automatic t_codes;
    logic [4:0] c;
    logic [31:0] e;
    logic rv;
    for (int i = 0; i < 32; i++) begin
      c = i[4:0];
      rv = c inside {5'h01, 5'h03, 5'h05, 5'h07, 5'h09, 5'h0a, 5'h0b};
      wr(4'h0, {23'h0, c, 4'h1});
      rd(4'h4);
      if (!rv && c != a_code) begin
        chk("pending", {1'h1, a_code}, {d[8], d[4:0]});
      end
      if (!rv) a_code = c;
      flip;
      // a refused reserved request stays pending
      e = exp_st(a_code, 1'h0, rv) | {23'h0, rv, 8'h00};
      sep <= e[6];
      rd(4'h4);
      chk("status", e, d);
      chk_video(e[5], e[6]);
    end
  endtask : t_codes

  task automatic t_ext;
    @(posedge clk);
    pin_code <= 5'h10;
    pin_ext <= 1'h1;
    wr(4'h0, 32'h0);
    flip;
    rd(4'h4);
    chk("pin ext", exp_st(5'h10, 1'h1, 1'h0), d);
    chk_video(1'h1, 1'h1);
    @(posedge clk);
    pin_ext <= 1'h0;
    wr(4'h0, 32'h2);
    flip;
    rd(4'h4);
    chk("bit ext", exp_st(5'h10, 1'h1, 1'h0), d);
    wr(4'h0, 32'h0);
    flip;
    rd(4'h4);
    chk("embedded sel", exp_st(5'h10, 1'h0, 1'h0), d);
  endtask : t_ext

  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'h0;
    t_regs();
    t_trs();
    t_codes();
    t_ext();
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_of_test();
  end
endmodule : vfs_top_tb
